// ### hdl/pce_pkg.sv
// Package: register map, field positions and reset values of the CRC engine
package pce_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned PCE_AW = 8;
    localparam int unsigned PCE_DW = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [PCE_AW-1:0] OFF_CTRL_ONE  = 8'h00;
    localparam logic [PCE_AW-1:0] OFF_CTRL_TWO  = 8'h04;
    localparam logic [PCE_AW-1:0] OFF_POLY_LO   = 8'h08;
    localparam logic [PCE_AW-1:0] OFF_POLY_HI   = 8'h0C;
    localparam logic [PCE_AW-1:0] OFF_DATA_LO   = 8'h10;
    localparam logic [PCE_AW-1:0] OFF_DATA_HI   = 8'h14;
    localparam logic [PCE_AW-1:0] OFF_RESULT_LO = 8'h18;
    localparam logic [PCE_AW-1:0] OFF_RESULT_HI = 8'h1C;

    // ------------------------------------------------------------------
    // engine_control_one fields
    // ------------------------------------------------------------------
    localparam int unsigned BIT_ENABLE   = 0;
    localparam int unsigned BIT_GO       = 1;
    localparam int unsigned BIT_IRQ_SEL  = 2;
    localparam int unsigned BIT_LSB      = 3;
    localparam int unsigned BIT_FULL     = 4;
    localparam int unsigned BIT_EMPTY    = 5;
    localparam int unsigned POS_VALID_WORD_COUNT    = 8;

    // ------------------------------------------------------------------
    // engine_control_two fields
    // ------------------------------------------------------------------
    localparam int unsigned POS_WIDTH    = 8;
    localparam int unsigned POS_POLY_LENGTH_FIELD     = 0;
    localparam int unsigned FIELD_W      = 5;

    // Words wider than a half-word need both data halves
    localparam logic [FIELD_W-1:0] NARROW_MAX_M1 = 5'h0F;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0]        RST_HALF  = 16'h0000;
    localparam logic [31:0]        RST_WORD  = 32'h0000_0000;
    localparam logic [FIELD_W-1:0] RST_FIELD = 5'h00;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } pce_state_t;

endpackage

// ### hdl/pce_crc_step.sv
// One bit step of a programmable-length, non-reflected CRC shift register
`timescale 1ns/100ps
`default_nettype none
module pce_crc_step (
    input  wire logic [31:0] crc_in,
    input  wire logic [31:0] poly,
    input  wire logic [4:0]  poly_length_field_m1,
    input  wire logic        din,
    output logic      [31:0] crc_out
);
    logic        feedback;
    logic [31:0] shifted;
    logic [31:0] keep_mask;

    always_comb begin
        // Top bit of the active length is the CRC output bit
        feedback  = crc_in[poly_length_field_m1] ^ din;
        shifted   = {crc_in[30:0], 1'b0};
        keep_mask = 32'hFFFFFFFF >> (5'd31 - poly_length_field_m1);
        // Polynomial bits choose which feedback taps exist
        crc_out   = (feedback ? (shifted ^ poly) : shifted) & keep_mask;
    end
endmodule
`default_nettype wire

// ### hdl/pce_top.sv
// Programmable CRC engine with input word FIFO and APB register slave
`timescale 1ns/100ps
`default_nettype none
module pce_top
    import pce_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 8
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [pce_pkg::PCE_AW-1:0] paddr,
    input  wire logic [pce_pkg::PCE_DW-1:0] pwdata,
    output logic      [pce_pkg::PCE_DW-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic                           crc_irq
);
    import pce_pkg::*;

    localparam int unsigned PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam logic [FIELD_W-1:0] DEPTH_CNT = FIELD_W'(FIFO_DEPTH);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                         engine_enable;
        logic                         calc_go;
        logic                         irq_mode_select;
        logic                         shift_lsb_first;
        logic [FIELD_W-1:0]           word_width_field;
        logic [FIELD_W-1:0]           poly_length_field;
        logic [15:0]                  poly_terms_low;
        logic [15:0]                  poly_terms_high;
        logic [15:0]                  data_low_hold;
        logic [31:0]                  result;
        logic [FIFO_DEPTH-1:0][31:0]  fifo;
        logic [PW-1:0]                wr_ptr;
        logic [PW-1:0]                rd_ptr;
        logic [FIELD_W-1:0]           valid_word_count;
        pce_state_t                   state;
        logic [31:0]                  word;
        logic [FIELD_W-1:0]           bit_idx;
        logic [31:0]                  rdata;
        logic                         slverr;
        logic                         irq;
    } pce_regs_t;

    pce_regs_t   s_r;
    pce_regs_t   s_nxt;

    logic        wr_acc;
    logic        rd_setup;
    logic        fifo_full_flag;
    logic        fifo_empty;
    logic        push;
    logic        pop;
    logic [31:0] push_word;
    logic        din;
    logic [31:0] step_crc;
    logic [31:0] rd_val;
    logic        rd_hit;

    assign fifo_full_flag = (s_r.valid_word_count == DEPTH_CNT);
    assign fifo_empty     = (s_r.valid_word_count == RST_FIELD);
    assign wr_acc         = psel & penable & pwrite;
    assign rd_setup       = psel & ~penable;

    // ------------------------------------------------------------------
    // Bit selection by shift direction
    // ------------------------------------------------------------------
    always_comb begin
        if (s_r.shift_lsb_first) begin
            din = s_r.word[s_r.bit_idx];
        end else begin
            din = s_r.word[s_r.word_width_field - s_r.bit_idx];
        end
    end

    pce_crc_step u_step (
        .crc_in  (s_r.result),
        .poly    ({s_r.poly_terms_high, s_r.poly_terms_low}),
        .poly_length_field_m1 (s_r.poly_length_field),
        .din     (din),
        .crc_out (step_crc)
    );

    // ------------------------------------------------------------------
    // Read mux and address decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_val = RST_WORD;
        rd_hit = 1'b1;
        unique case (paddr)
            OFF_CTRL_ONE: begin
                rd_val[BIT_ENABLE]  = s_r.engine_enable;
                rd_val[BIT_GO]      = s_r.calc_go;
                rd_val[BIT_IRQ_SEL] = s_r.irq_mode_select;
                rd_val[BIT_LSB]     = s_r.shift_lsb_first;
                rd_val[BIT_FULL]    = fifo_full_flag;
                rd_val[BIT_EMPTY]   = fifo_empty;
                rd_val[POS_VALID_WORD_COUNT +: FIELD_W] = s_r.valid_word_count;
            end
            OFF_CTRL_TWO: begin
                rd_val[POS_WIDTH +: FIELD_W] = s_r.word_width_field;
                rd_val[POS_POLY_LENGTH_FIELD +: FIELD_W]  = s_r.poly_length_field;
            end
            OFF_POLY_LO:   rd_val[15:0] = s_r.poly_terms_low;
            OFF_POLY_HI:   rd_val[15:0] = s_r.poly_terms_high;
            OFF_DATA_LO:   rd_val[15:0] = s_r.data_low_hold;
            OFF_DATA_HI:   rd_val = RST_WORD;
            OFF_RESULT_LO: rd_val[15:0] = s_r.result[15:0];
            OFF_RESULT_HI: rd_val[15:0] = s_r.result[31:16];
            default:       rd_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt     = s_r;
        s_nxt.irq = 1'b0;
        push      = 1'b0;
        pop       = 1'b0;
        push_word = RST_WORD;

        // Read data is caught in the setup phase so the access phase
        // answers from flip-flops with no wait state
        if (rd_setup) begin
            s_nxt.rdata  = rd_val;
            s_nxt.slverr = ~rd_hit;
        end

        // Engine
        unique case (s_r.state)
            ST_IDLE: begin
                if (s_r.calc_go && !fifo_empty) begin
                    s_nxt.word    = s_r.fifo[s_r.rd_ptr];
                    s_nxt.bit_idx = RST_FIELD;
                    s_nxt.state   = ST_SHIFT;
                    pop           = 1'b1;
                end else if (s_r.calc_go) begin
                    s_nxt.calc_go = 1'b0;
                    s_nxt.irq     = s_r.irq_mode_select;
                end
            end
            ST_SHIFT: begin
                if (!s_r.calc_go) begin
                    s_nxt.state = ST_IDLE;
                end else begin
                    s_nxt.result  = step_crc;
                    s_nxt.bit_idx = s_r.bit_idx + 5'd1;
                    if (s_r.bit_idx == s_r.word_width_field) begin
                        s_nxt.state = ST_IDLE;
                    end
                end
            end
        endcase

        // Register writes override the engine in the same cycle
        if (wr_acc) begin
            unique case (paddr)
                OFF_CTRL_ONE: begin
                    s_nxt.engine_enable   = pwdata[BIT_ENABLE];
                    s_nxt.irq_mode_select = pwdata[BIT_IRQ_SEL];
                    s_nxt.shift_lsb_first = pwdata[BIT_LSB];
                    s_nxt.calc_go         = pwdata[BIT_GO] & pwdata[BIT_ENABLE];
                    if (!pwdata[BIT_GO]) begin
                        s_nxt.irq = 1'b0;
                    end
                end
                OFF_CTRL_TWO: begin
                    s_nxt.word_width_field  = pwdata[POS_WIDTH +: FIELD_W];
                    s_nxt.poly_length_field = pwdata[POS_POLY_LENGTH_FIELD +: FIELD_W];
                end
                OFF_POLY_LO: s_nxt.poly_terms_low  = pwdata[15:0];
                OFF_POLY_HI: s_nxt.poly_terms_high = pwdata[15:0];
                OFF_DATA_LO: begin
                    s_nxt.data_low_hold = pwdata[15:0];
                    if (s_r.word_width_field <= NARROW_MAX_M1) begin
                        push      = 1'b1;
                        push_word = {16'h0000, pwdata[15:0]};
                    end
                end
                OFF_DATA_HI: begin
                    if (s_r.word_width_field > NARROW_MAX_M1) begin
                        push      = 1'b1;
                        push_word = {pwdata[15:0], s_r.data_low_hold};
                    end
                end
                OFF_RESULT_LO: s_nxt.result[15:0]  = pwdata[15:0];
                OFF_RESULT_HI: s_nxt.result[31:16] = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // A disabled engine cannot run
        if (!s_nxt.engine_enable) begin
            s_nxt.calc_go = 1'b0;
            s_nxt.state   = ST_IDLE;
        end

        // FIFO; a push into a full FIFO is dropped
        if (push && !fifo_full_flag) begin
            s_nxt.fifo[s_r.wr_ptr] = push_word;
            s_nxt.wr_ptr           = s_r.wr_ptr + PW'(1);
        end else begin
            push = 1'b0;
        end
        if (pop) begin
            s_nxt.rd_ptr = s_r.rd_ptr + PW'(1);
        end
        s_nxt.valid_word_count = s_r.valid_word_count
                               + FIELD_W'(push) - FIELD_W'(pop);

        if (!s_r.irq_mode_select && s_r.valid_word_count == 5'd1
                && s_nxt.valid_word_count == RST_FIELD) begin
            s_nxt.irq = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.engine_enable     <= 1'b0;
            s_r.calc_go           <= 1'b0;
            s_r.irq_mode_select   <= 1'b0;
            s_r.shift_lsb_first   <= 1'b0;
            s_r.word_width_field  <= RST_FIELD;
            s_r.poly_length_field <= RST_FIELD;
            s_r.poly_terms_low    <= RST_HALF;
            s_r.poly_terms_high   <= RST_HALF;
            s_r.data_low_hold     <= RST_HALF;
            s_r.result            <= RST_WORD;
            s_r.fifo              <= '0;
            s_r.wr_ptr            <= '0;
            s_r.rd_ptr            <= '0;
            s_r.valid_word_count  <= RST_FIELD;
            s_r.state             <= ST_IDLE;
            s_r.word              <= RST_WORD;
            s_r.bit_idx           <= RST_FIELD;
            s_r.rdata             <= RST_WORD;
            s_r.slverr            <= 1'b0;
            s_r.irq               <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata  = s_r.rdata;
    assign pslverr = s_r.slverr & psel & penable;
    assign pready  = psel & penable;
    assign crc_irq = s_r.irq;

endmodule
`default_nettype wire

// ### verif/pce_asserts.sv
// Checker: bus answer and interrupt timing of the CRC engine
`timescale 1ns/100ps
`default_nettype none
module pce_asserts
    import pce_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [PCE_AW-1:0] paddr,
    input wire logic [PCE_DW-1:0] pwdata,
    input wire logic [PCE_DW-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              crc_irq
);
    // ----
    // Bus phases
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd; psel && penable && !pwrite; endsequence
    sequence s_unmap; psel && penable && paddr > 8'h1C; endsequence
    // A stale count pulse may still land one cycle after the abort write
    sequence s_abort;
        psel && penable && pwrite && paddr == OFF_CTRL_ONE
            && !pwdata[BIT_GO] && pwdata[BIT_IRQ_SEL];
    endsequence

    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready does not follow the access phase");
    a_err_unmapped: assert property (s_unmap |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_mapped: assert property (psel && penable && paddr <= 8'h1C
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged as error");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error flag outside an access");
    a_unmap_rdzero: assert property (s_unmap ##0 !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_rdata_hold: assert property (s_setup ##1 s_rd |=> $stable(prdata))
        else $error("read data moved after the access");
    a_irq_pulse: assert property (crc_irq |=> !crc_irq)
        else $error("interrupt longer than one cycle");
    a_abort_quiet: assert property (s_abort |=> ##1 (!crc_irq)[*6])
        else $error("interrupt after software cleared go");
endmodule
bind pce_top pce_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crc_irq(crc_irq)
);
`default_nettype wire

// ### verif/pce_top_tb_top.sv
// Self-checking testbench for the programmable CRC engine
`timescale 1ns/100ps
`default_nettype none
module pce_top_tb_top;
    import pce_pkg::*;
    localparam int unsigned DEPTH = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, crc_irq, berr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, lo, crc, last_crc;
    int          n_errors = 0;
    int          checked = 0;
    int          n_irq = 0;
    int          i0;

    pce_top #(.FIFO_DEPTH(DEPTH)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crc_irq(crc_irq)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (crc_irq === 1'b1) n_irq++;

    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        berr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] step(input logic [31:0] c, p, w, input int pl, wd,
                                         input logic lsb);
        logic [31:0] m;
        logic        fb;
        m = (pl == 32) ? 32'hFFFF_FFFF : ((32'h1 << pl) - 32'h1);
        for (int i = 0; i < wd; i++) begin
            fb = c[pl-1] ^ (lsb ? w[i] : w[wd-1-i]);
            c = ((c << 1) ^ (fb ? p : 32'h0)) & m;
        end
        return c;
    endfunction

    task automatic finish_calc();
        rd = 32'h2;
        for (int k = 0; k < 100 && rd[BIT_GO]; k++) apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk("calc_go", 32'h0, {31'h0, rd[BIT_GO]});
        repeat (2) @(posedge pclk);
        chk("irq count", 32'h1, 32'(n_irq - i0));
        apb(1'b0, OFF_RESULT_LO, 32'h0);
        lo = rd;
        apb(1'b0, OFF_RESULT_HI, 32'h0);
        chk("result", crc, {rd[15:0], lo[15:0]});
        last_crc = crc;
    endtask

    task automatic setup(input logic [31:0] p, input logic [4:0] pm, wm, input logic clr);
        apb(1'b1, OFF_CTRL_ONE, 32'h1);
        apb(1'b1, OFF_CTRL_TWO, {19'h0, wm, 3'h0, pm});
        apb(1'b1, OFF_POLY_LO, {16'h0, p[15:0]});
        apb(1'b1, OFF_POLY_HI, {16'h0, p[31:16]});
        crc = clr ? 32'h0 : last_crc;
        if (clr) apb(1'b1, OFF_RESULT_LO, 32'h0);
        if (clr) apb(1'b1, OFF_RESULT_HI, 32'h0);
    endtask

    task automatic run(input logic [31:0] p, input logic [4:0] pm, wm,
                       input logic lsb, md, clr, input int n);
        logic [31:0] w;
        setup(p, pm, wm, clr);
        for (int i = 0; i < n; i++) begin
            // Wide words go as two halves, the high half pushes the word
            w = (32'hA5C3_96E1 ^ 32'(i * 7919)) >> (5'd31 - wm);
            apb(1'b1, OFF_DATA_LO, {16'h0, w[15:0]});
            if (wm > NARROW_MAX_M1) apb(1'b1, OFF_DATA_HI, {16'h0, w[31:16]});
            crc = step(crc, p, w, pm + 1, wm + 1, lsb);
        end
        i0 = n_irq;
        apb(1'b1, OFF_CTRL_ONE, {28'h0, lsb, md, 2'h3});
        finish_calc();
    endtask

    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        print_verdict();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk("ctrl_one reset", 32'h1 << BIT_EMPTY, rd & 32'h1F3F);
        for (int a = 4; a < 32; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk("wr pslverr", 32'h1, {31'h0, berr});
        apb(1'b0, 8'h40, 32'h0);
        chk("rd unmapped", 32'h1, {rd[30:0], berr});
        run(32'h0000_1021, 5'd15, 5'd7, 1'b0, 1'b1, 1'b1, 3);
        run(32'h0000_1021, 5'd15, 5'd7, 1'b1, 1'b0, 1'b1, 3);
        run(32'h04C1_1DB7, 5'd31, 5'd31, 1'b0, 1'b1, 1'b1, 2);
        run(32'h0000_0005, 5'd4, 5'd4, 1'b1, 1'b1, 1'b1, 2);
        run(32'h0000_0005, 5'd4, 5'd4, 1'b1, 1'b0, 1'b0, 2);
        setup(32'h0000_1021, 5'd15, 5'd15, 1'b1);
        for (int i = 1; i <= DEPTH; i++) begin
            apb(1'b1, OFF_DATA_LO, 32'(i));
            crc = step(crc, 32'h1021, 32'(i), 16, 16, 1'b0);
        end
        apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk("full flag", {26'h0, 5'(DEPTH), 1'b1}, {26'h0, rd[12:8], rd[BIT_FULL]});
        apb(1'b1, OFF_DATA_LO, 32'h0000_BEEF);
        i0 = n_irq;
        apb(1'b1, OFF_CTRL_ONE, 32'h3);
        apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk("after pop", {26'h0, 5'(DEPTH - 1), 1'b0}, {26'h0, rd[12:8], rd[BIT_FULL]});
        finish_calc();
        apb(1'b1, OFF_DATA_LO, 32'h0000_1234);
        apb(1'b1, OFF_DATA_LO, 32'h0000_5678);
        i0 = n_irq;
        apb(1'b1, OFF_CTRL_ONE, 32'h7);
        repeat (5) @(posedge pclk);
        apb(1'b1, OFF_CTRL_ONE, 32'h5);
        repeat (60) @(posedge pclk);
        chk("abort irq", 32'h0, 32'(n_irq - i0));
        apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk("abort go", 32'h0, {31'h0, rd[BIT_GO]});
        print_verdict();
    end
endmodule
`default_nettype wire
